/* File: dv/pin_bank_checker.sv */
/*
  Port assertions for the pin bank.
  Bound to every pin_bank instance; sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_bank_checker
  import pin_bank_pkg::*;
#(
  parameter int unsigned PIN_W = 8            // Pins in the bank
) (
  input wire logic             clk_in,               // Core clock
  input wire logic             sys_rst_in,           // Async reset
  input wire logic             rd_in,                // Read strobe
  input wire logic [7:0]       rdata_out,            // Read data
  input wire logic [PIN_W-1:0] pin_in,               // Pin levels
  input wire logic [PIN_W-1:0] pin_out,              // Drive values
  input wire logic [PIN_W-1:0] pin_oe_out,           // Drive enables
  input wire logic [1:0]       osc_claim_in,         // Oscillator claims
  input wire logic             reset_pin_select_in,  // Bit five is reset
  input wire logic [2:0]       cmp_mode_out,         // Comparator mode
  input wire logic             cmp_ground_out,       // Inputs grounded
  input wire logic [PIN_W-1:0] analog_sel_out,       // Analog pins
  input wire logic             vref_drive_out,       // Reference on pin
  input wire logic             timer_zero_clock_in_out, // Timer clock
  input wire logic             ext_reset_n_out       // Reset from pin
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_rd_quiet: assert property (!$past(rd_in) |-> rdata_out == ZERO_BYTE)
    else $error("read data outside its cycle");
  a_pin5_off: assert property (pin_oe_out[PIN_IN5] == 1'b0)
    else $error("input-only pin driven");
  a_od_low: assert property (pin_oe_out[PIN_OD] |-> !pin_out[PIN_OD])
    else $error("open-drain pin driven high");
  a_ground_map: assert property (cmp_ground_out == (cmp_mode_out == CM_RESET))
    else $error("comparator ground wrong for mode");
  a_analog_map: assert property (analog_sel_out == ((cmp_mode_out == CM_OFF) ? AN_NONE :
    ((cmp_mode_out == CM_OUTPUTS) ? AN_OUT_MODE : AN_ALL_LOW)))
    else $error("analog pin mask wrong for mode");
  a_claim_hi: assert property (osc_claim_in[1] && $past(osc_claim_in[1])
    |-> !pin_oe_out[PIN_OSC_H]) else $error("claimed pin driven");
  a_vref_pin: assert property (vref_drive_out && $past(vref_drive_out)
    |-> !pin_oe_out[PIN_REF]) else $error("reference pin driven digitally");
  a_rst_unsel: assert property (!reset_pin_select_in [*3] |=> ext_reset_n_out)
    else $error("pin reset active while unselected");
  a_tclk_sync: assert property (($stable(pin_in[PIN_OD]) && !$past(sys_rst_in, 4)) [*4]
    |-> timer_zero_clock_in_out == pin_in[PIN_OD]) else $error("timer clock lags pin");
endmodule : pin_bank_checker

bind pin_bank pin_bank_checker #(.PIN_W(PIN_W)) chk (.*);
`default_nettype wire

/* File: dv/pin_board_model.sv */
/*
  Board side of the pin bank: pulls and high-impedance loads.
  Assumes drive values and enables come straight from the bank.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_board_model #(
  parameter int unsigned PIN_W = 8              // Pins on the board
) (
  input  wire logic [PIN_W-1:0] drive_in,       // Bank drive values
  input  wire logic [PIN_W-1:0] drive_en_in,    // Bank drive enables
  input  wire logic [PIN_W-1:0] pull_in,        // Board pull levels
  output logic      [PIN_W-1:0] level_out       // Resolved pin levels
);
  // Released pins fall to the board pull; loads are high impedance
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      level_out[i] = drive_en_in[i] ? drive_in[i] : pull_in[i];
    end
  end
endmodule : pin_board_model
`default_nettype wire

/* File: dv/tb.sv */
/*
  Self-checking bench: pin bank against an integer model.
  Assumes the checker is bound and the board model resolves pins.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pin_bank_pkg::*;
  logic        clk_in, sys_rst_in, wr_in, rd_in, cmp1_res_in, cmp2_res_in;
  logic        reset_pin_select_in, cmp_ground_out, vref_drive_out;
  logic        timer_zero_clock_in_out, ext_reset_n_out;
  logic [1:0]  osc_claim_in;
  logic [2:0]  cmp_mode_out;
  logic [7:0]  addr_in, wdata_in, wmask_in, rdata_out, pin_in, pin_out, pin_oe_out;
  logic [7:0]  analog_sel_out, ext_lvl, dir, lat, vref, m, d;  // Model state
  logic [31:0] seed = 32'hB0142818;
  int          bad_count, total_checks;

  pin_bank DUT (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wmask_in, .wr_in, .rd_in,
    .rdata_out, .pin_in, .pin_out, .pin_oe_out, .cmp1_res_in, .cmp2_res_in,
    .osc_claim_in, .reset_pin_select_in, .cmp_mode_out, .cmp_ground_out,
    .analog_sel_out, .vref_drive_out, .timer_zero_clock_in_out, .ext_reset_n_out);
  pin_board_model brd (.drive_in(pin_out), .drive_en_in(pin_oe_out), .pull_in(ext_lvl),
    .level_out(pin_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected enables; shared functions win over the direction bits
  function automatic logic [7:0] oe_exp();
    logic [7:0] o;
    o = ~dir;
    o[PIN_IN5] = 1'b0;
    o[PIN_OD] = ~dir[PIN_OD] & ~lat[PIN_OD];
    o[7:6] = o[7:6] & ~osc_claim_in;
    if (vref[VREF_EN] & vref[VREF_OE]) o[PIN_REF] = 1'b0;
    return o;
  endfunction : oe_exp

  // Pin levels; open-drain pin only ever pulls low
  function automatic logic [7:0] lvl_exp();
    return (oe_exp() & lat & 8'hEF) | (~oe_exp() & ext_lvl);
  endfunction : lvl_exp

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Single-cycle strobes, held until the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] mk);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wmask_in <= mk;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    chk(rdata_out, e);
  endtask : rd

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Hang guard
  initial begin
    #500000;
    bad_count++;
    test_done();
  end

  initial begin
    {wr_in, rd_in, cmp1_res_in, cmp2_res_in, reset_pin_select_in} = '0;
    {addr_in, wdata_in, wmask_in, osc_claim_in} = '0;
    ext_lvl = 8'hA5;
    dir = RST_DIR;
    lat = RST_LATCH;
    vref = RST_VREF;
    sys_rst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(pin_oe_out, 8'h00);
    chk(analog_sel_out, AN_ALL_LOW);
    chk({7'h0, cmp_ground_out}, 8'h01);
    rd(ADDR_DIR, RST_DIR);
    rd(ADDR_DATA, lvl_exp() & ~AN_ALL_LOW);
    rd(8'h40, ZERO_BYTE);
    // A mode from the default group: low four pins analog, not grounded
    wr(ADDR_CMP, 8'h02, 8'h00);
    repeat (2) @(posedge clk_in);
    #1;
    chk(analog_sel_out, AN_ALL_LOW);
    chk({7'h0, cmp_ground_out}, 8'h00);
    wr(ADDR_CMP, {5'h0, CM_OFF}, 8'h00);
    rd(ADDR_CMP, {5'h0, CM_OFF});
    chk(analog_sel_out, AN_NONE);
    // Random direction, sharing and read-modify-write rounds
    for (int k = 0; k < 10; k++) begin
      ext_lvl <= 8'(xs());
      osc_claim_in <= 2'(xs());
      reset_pin_select_in <= 1'(xs());
      vref = 8'(xs()) & VREF_WMASK;
      dir = 8'(xs());
      wr(ADDR_VREF, vref, 8'h00);
      wr(ADDR_DIR, dir, 8'h00);
      repeat (4) @(posedge clk_in);
      m = 8'(xs()) | 8'hE0;
      d = 8'(xs());
      lat = (d & m) | (lvl_exp() & ~m);
      wr(ADDR_DATA, d, m);
      repeat (4) @(posedge clk_in);
      #1;
      chk(pin_oe_out, oe_exp());
      chk(pin_out & oe_exp(), lat & 8'hEF & oe_exp());
      chk({7'h0, vref_drive_out}, {7'h0, vref[7] & vref[6]});
      chk({7'h0, ext_reset_n_out}, {7'h0, ~reset_pin_select_in | ext_lvl[5]});
      rd(ADDR_DATA, lvl_exp() & {~osc_claim_in, ~reset_pin_select_in, 5'h1F});
      rd(ADDR_VREF, vref);
    end
    // Comparator results onto pins 3 and 4
    cmp1_res_in <= 1'b1;
    dir = 8'h00;
    wr(ADDR_DIR, dir, 8'h00);
    wr(ADDR_CMP, {5'h0, CM_OUTPUTS}, 8'h00);
    repeat (3) @(posedge clk_in);
    #1;
    chk({5'h0, pin_out[PIN_CMP1], pin_oe_out[4:3]}, 8'h07);
    chk(analog_sel_out, AN_OUT_MODE);
    rd(ADDR_CMP, 8'h46);
    cmp1_res_in <= 1'b0;
    wr(ADDR_CMP, 8'hE6, 8'h00);
    repeat (3) @(posedge clk_in);
    #1;
    chk({6'h0, pin_out[PIN_CMP1], pin_oe_out[PIN_OD]}, 8'h00);
    rd(ADDR_CMP, 8'hA6);
    test_done();
  end
endmodule : tb
`default_nettype wire

/* File: rtl/pin_bank.sv */
/*
  Eight-bit general-purpose pin bank whose pins are shared with
  comparator inputs and outputs, a reference output, a timer clock
  input, oscillator pins and the external reset input.
  Assumes a byte register port (read data one cycle after the strobe),
  on-chip comparator results synchronous to clk_in, and a board that
  resolves each pin from pin_out and pin_oe.
*/
// The address-and-strobe port and the address map were left to the implementer.
// Functional notes
// - Eight-bit output latch, one bit per pin
// - Direction one tristates, zero drives latch bit
// - Data read gives pins, write updates latch
// - Writes sample pins, modify bits, store latch
// - Comparator input pins read back as zero
// - Reset: all inputs, low pins analog, grounded
// - Oscillator-claimed pins ignore direction, read zero
// - Bit five never drives its pin
// - Bit four open drain, also timer clock
// - Direction still gates drivers on analog pins
// - Output mode drives comparator results when direction clear
// - Enabled peripheral takes the shared pin over
// - Mode seven turns comparators off, pins digital
// - Configuration selects bit five as reset input
`timescale 1ns/10ps
`default_nettype none

module pin_bank
  import pin_bank_pkg::*;
#(
  parameter int unsigned PIN_W = 8           // Pins in the bank
) (
  input  wire logic             clk_in,        // Core clock, 100 MHz
  input  wire logic             sys_rst_in,    // Async reset, high
  input  wire logic [7:0]       addr_in,       // Register address
  input  wire logic [7:0]       wdata_in,      // Write data
  input  wire logic [7:0]       wmask_in,      // Bits a data write modifies
  input  wire logic             wr_in,         // Write strobe
  input  wire logic             rd_in,         // Read strobe
  output logic      [7:0]       rdata_out,     // Read data, next cycle
  input  wire logic [PIN_W-1:0] pin_in,        // Pin levels
  output logic      [PIN_W-1:0] pin_out,       // Pin drive values
  output logic      [PIN_W-1:0] pin_oe_out,    // Pin drive enables
  input  wire logic             cmp1_res_in,   // Comparator 1 raw result
  input  wire logic             cmp2_res_in,   // Comparator 2 raw result
  input  wire logic [1:0]       osc_claim_in,  // Oscillator owns pins 6/7
  input  wire logic             reset_pin_select_in, // Bit five is reset
  output logic      [2:0]       cmp_mode_out,  // Mode to comparators
  output logic                  cmp_ground_out, // Tie comparator inputs low
  output logic      [PIN_W-1:0] analog_sel_out, // Pins used as analog inputs
  output logic                  vref_drive_out, // Reference onto pin 2
  output logic                  timer_zero_clock_in_out, // Timer clock
  output logic                  ext_reset_n_out // Reset from pin, low
);

  // Whole state of the block in one record
  typedef struct packed {
    logic [PIN_W-1:0] sync1;      // First synchroniser stage
    logic [PIN_W-1:0] sync2;      // Second synchroniser stage
    logic [PIN_W-1:0] latch;      // Output latch
    logic [PIN_W-1:0] dir;        // Direction, one is input
    logic [7:0]       cmp;        // Comparator control, writable part
    logic [7:0]       vref;       // Reference control
    logic [7:0]       rdata;      // Read data register
    logic [PIN_W-1:0] pout;       // Registered pin values
    logic [PIN_W-1:0] poe;        // Registered pin enables
    logic [PIN_W-1:0] an_sel;     // Registered analog selection
    logic             ground;     // Comparator inputs tied low
    logic             vref_drv;   // Reference pin drive
    logic             tclk;       // Timer clock copy
    logic             rst_n;      // Reset from pin
  } state_t;

  state_t st_r;                   // Current state
  state_t st_nxt;                 // Next state

  // Pins used as comparator inputs in a given mode
  function automatic logic [7:0] analog_mask(input logic [2:0] mode);
    logic [7:0] m;
    m = AN_ALL_LOW;
    case (mode)
      CM_OFF:     m = AN_NONE;      // All digital again
      CM_OUTPUTS: m = AN_OUT_MODE;  // Pins 3/4 become outputs
      default:    m = AN_ALL_LOW;   // Low four pins analog
    endcase
    return m;
  endfunction : analog_mask

  // Pin levels as software sees them on a data read
  function automatic logic [7:0] visible_pins(
    input logic [7:0] lvl,
    input logic [7:0] an,
    input logic [1:0] osc,
    input logic       rsel
  );
    logic [7:0] v;
    v = lvl & ~an;
    if (osc[0]) begin
      v[PIN_OSC_L] = 1'b0;
    end
    if (osc[1]) begin
      v[PIN_OSC_H] = 1'b0;
    end
    if (rsel) begin
      v[PIN_IN5] = 1'b0;                 // Reset pin, not data
    end
    return v;
  endfunction : visible_pins

  logic [2:0] mode;               // Current comparator mode
  logic [7:0] an_mask;            // Current analog pin mask
  logic [7:0] seen;               // Pins as read by software
  logic       c1;                 // Comparator 1 after inversion
  logic       c2;                 // Comparator 2 after inversion
  logic [7:0] cmp_rd;             // Comparator control read value
  logic [7:0] drv;                // Per-pin drive before overrides
  logic [7:0] en;                 // Per-pin enable before overrides

  // Next-state logic
  always_comb begin
    st_nxt  = st_r;
    mode    = st_r.cmp[CMP_MODE_HI:0];
    an_mask = analog_mask(mode);
    // Only synchronised levels are used, the raw pins are metastable
    seen    = visible_pins(st_r.sync2, an_mask,
                           osc_claim_in, reset_pin_select_in);
    c1      = cmp1_res_in ^ st_r.cmp[CMP_C1INV];
    c2      = cmp2_res_in ^ st_r.cmp[CMP_C2INV];
    cmp_rd  = st_r.cmp;
    cmp_rd[CMP_C1OUT] = c1;
    cmp_rd[CMP_C2OUT] = c2;

    // Pin synchroniser, two stages
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;

    // Register writes
    if (wr_in) begin
      case (addr_in)
        ADDR_DATA: begin
          // Untouched bits take the pin level, as on the real port
          st_nxt.latch = (seen & ~wmask_in)
                       | (wdata_in & wmask_in);
        end
        ADDR_DIR: begin
          st_nxt.dir = wdata_in;
        end
        ADDR_CMP: begin
          // Result bits are read only
          st_nxt.cmp[CMP_WR_HI:0] = wdata_in[CMP_WR_HI:0];
        end
        ADDR_VREF: begin
          st_nxt.vref = wdata_in & VREF_WMASK;
        end
        default: begin
          st_nxt.rdata = st_r.rdata; // Unmapped write ignored
        end
      endcase
    end

    // Register reads, data valid in the next cycle only
    st_nxt.rdata = ZERO_BYTE;
    if (rd_in) begin
      case (addr_in)
        ADDR_DATA: st_nxt.rdata = seen;
        ADDR_DIR:  st_nxt.rdata = st_r.dir;
        ADDR_CMP:  st_nxt.rdata = cmp_rd;
        ADDR_VREF: st_nxt.rdata = st_r.vref;
        default:   st_nxt.rdata = ZERO_BYTE;         // Unmapped reads zero
      endcase
    end

    // Plain port drive: latch when direction is zero
    drv = st_r.latch;
    en  = ~st_r.dir;

    // Comparator output mode takes pins 3 and 4
    if (mode == CM_OUTPUTS) begin
      drv[PIN_CMP1] = c1;
      drv[PIN_OD]   = c2;
    end

    // Open drain: only ever pulls low
    en[PIN_OD]  = ~st_r.dir[PIN_OD] & ~drv[PIN_OD];
    drv[PIN_OD] = 1'b0;

    // Input-only pin has no driver at all
    en[PIN_IN5]  = 1'b0;
    drv[PIN_IN5] = 1'b0;

    // Oscillator owns the top pins, direction ignored
    if (osc_claim_in[0]) begin
      en[PIN_OSC_L]  = 1'b0;
      drv[PIN_OSC_L] = 1'b0;
    end
    if (osc_claim_in[1]) begin
      en[PIN_OSC_H]  = 1'b0;
      drv[PIN_OSC_H] = 1'b0;
    end

    // Reference output: analog driver, digital one kept off
    // Software is expected to leave pin 2 an input here anyway
    st_nxt.vref_drv = st_r.vref[VREF_EN] & st_r.vref[VREF_OE];
    if (st_nxt.vref_drv) begin
      en[PIN_REF] = 1'b0;
    end

    st_nxt.pout   = drv;
    st_nxt.poe    = en;
    // Mask and ground follow the next mode, so they change in the
    // same cycle as the mode output instead of one cycle behind it
    st_nxt.an_sel = analog_mask(st_nxt.cmp[CMP_MODE_HI:0]);
    // Reset mode grounds inputs to save current
    st_nxt.ground = (st_nxt.cmp[CMP_MODE_HI:0] == CM_RESET);

    // Timer clock is the synchronised open-drain pin
    st_nxt.tclk  = st_r.sync2[PIN_OD];
    // Bit five as external reset when configured
    st_nxt.rst_n = reset_pin_select_in ? st_r.sync2[PIN_IN5] : 1'b1;
  end

  // State register, reset puts the bank in its safe state
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r.sync1    <= '0;
      st_r.sync2    <= '0;
      st_r.latch    <= RST_LATCH;
      st_r.dir      <= RST_DIR;
      st_r.cmp      <= RST_CMP;
      st_r.vref     <= RST_VREF;
      st_r.rdata    <= ZERO_BYTE;
      st_r.pout     <= '0;
      st_r.poe      <= '0;
      st_r.an_sel   <= AN_ALL_LOW;
      st_r.ground   <= 1'b1;
      st_r.vref_drv <= 1'b0;
      st_r.tclk     <= 1'b0;
      st_r.rst_n    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state record
  assign rdata_out               = st_r.rdata;
  assign pin_out                 = st_r.pout;
  assign pin_oe_out              = st_r.poe;
  assign cmp_mode_out            = st_r.cmp[CMP_MODE_HI:0];
  assign cmp_ground_out          = st_r.ground;
  assign analog_sel_out          = st_r.an_sel;
  assign vref_drive_out          = st_r.vref_drv;
  assign timer_zero_clock_in_out = st_r.tclk;
  assign ext_reset_n_out         = st_r.rst_n;

endmodule : pin_bank

`default_nettype wire

/* File: rtl/pin_bank_pkg.sv */
/*
  Constants for the eight-bit pin bank with comparator sharing:
  register offsets, reset values, field positions, comparator modes.
  Assumes a byte-wide register port with an eight-bit address.
*/
package pin_bank_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_DATA  = 8'h05; // first_pin_bank_data
  localparam logic [7:0] ADDR_DIR   = 8'h85; // first_bank_direction
  localparam logic [7:0] ADDR_CMP   = 8'h1F; // comparator_control
  localparam logic [7:0] ADDR_VREF  = 8'h9F; // voltage_ref_control

  // Reset values
  localparam logic [7:0] RST_LATCH  = 8'h00; // Output latch
  localparam logic [7:0] RST_DIR    = 8'hFF; // All pins inputs
  localparam logic [7:0] RST_CMP    = 8'h00; // Comparators in reset mode
  localparam logic [7:0] RST_VREF   = 8'h00; // Reference off
  localparam logic [7:0] ZERO_BYTE  = 8'h00; // Empty read / cleared byte

  // Pin positions
  localparam int unsigned PIN_REF   = 2;     // ref_output_pin
  localparam int unsigned PIN_CMP1  = 3;     // comparator_one_out_pin
  localparam int unsigned PIN_OD    = 4;     // open_drain_pin
  localparam int unsigned PIN_IN5   = 5;     // input_only_pin
  localparam int unsigned PIN_OSC_L = 6;     // Lower oscillator pin
  localparam int unsigned PIN_OSC_H = 7;     // Upper oscillator pin

  // comparator_control field positions
  localparam int unsigned CMP_C2OUT = 7;     // Comparator 2 result (read only)
  localparam int unsigned CMP_C1OUT = 6;     // Comparator 1 result (read only)
  localparam int unsigned CMP_C2INV = 5;     // Invert comparator 2
  localparam int unsigned CMP_C1INV = 4;     // Invert comparator 1
  localparam int unsigned CMP_MODE_HI = 2;   // Mode field top bit
  localparam int unsigned CMP_WR_HI = 5;     // Highest writable bit

  // voltage_ref_control field positions
  localparam int unsigned VREF_EN   = 7;     // Reference enable
  localparam int unsigned VREF_OE   = 6;     // Reference drives pin 2
  localparam logic [7:0]  VREF_WMASK = 8'hEF; // Bit 4 not implemented

  // Comparator modes
  localparam logic [2:0] CM_RESET   = 3'h0;  // Inputs tied low
  localparam logic [2:0] CM_OUTPUTS = 3'h6;  // Results drive pins 3 and 4
  localparam logic [2:0] CM_OFF     = 3'h7;  // Comparators off, pins digital

  // Analog input masks per mode
  localparam logic [7:0] AN_ALL_LOW = 8'h0F; // low_analog_pins all analog
  localparam logic [7:0] AN_OUT_MODE = 8'h07; // Pins 0..2 analog
  localparam logic [7:0] AN_NONE    = 8'h00; // No analog pins

endpackage : pin_bank_pkg
